// ===== smbrp_pkg.sv
// constants for the smbus slave register port
package smbrp_pkg;
  localparam logic [4:0] ADDR_HIGH_BITS   = 5'h0b;
  localparam logic [6:0] ADDR_DEFAULT     = 7'h2e;
  localparam logic [6:0] ADDR_SEL_LOW     = 7'h2c;
  localparam logic [6:0] ADDR_SEL_HIGH    = 7'h2d;
  localparam logic [6:0] ALERT_RESP_ADDR  = 7'h0c;
  localparam logic [7:0] REG_GEN_CFG_ONE  = 8'h40;
  localparam int         TIMEOUT_OFF_BIT  = 6;
  localparam logic [7:0] GEN_CFG_ONE_RST  = 8'h00;
  localparam int         TIMEOUT_MS       = 35;
  localparam int         CLK_HZ           = 20000000;
  localparam int         TIMEOUT_CYCLES   = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int         BITS_PER_BYTE    = 8;
endpackage

// ===== smbrp_top.sv
// smbus slave port giving a master access to an internal register file
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RL1: each byte is eight data bits plus one acknowledge bit.
// RL2: sda moves only while scl low; sda rising with scl high is stop. (a timeout here releases sda even while scl is high)
// RL3: master ends a write with a stop on the tenth pulse.
// RL4: master ends a read with not-acknowledge, then stop.
// RL5: direction bit fixes the transfer; reads and writes never mix.
// RL6: accept one or two written bytes; reads return one byte.
// RL7: first written byte loads the address pointer.
// RL8: second written byte goes into the register the pointer selects.
// RL9: pointer persists; reads use the retained pointer.
// RL10: slave address is 01011 plus two strap-chosen low bits.
// RL11: repeated start begins a fresh operation.
// RL12: send byte: address, ack, command code, ack, stop.
// RL13: write byte: address, command, data, each acknowledged, stop.
// RL14: repeated start after pointer set reads from the new pointer.
// RL15: receive byte: address read, ack, one byte out, nack, stop.
// RL16: while alerting, answer alert response address with own address.
// RL17: alert response arbitration; a losing device stops driving sda.
// RL18: alert is released only when the cause has gone.
// RL19: 35 ms without bus activity mid-transfer returns port to idle.
// RL20: general config one bit 6 set disables the timeout.
// RL21: enable strap high gives 0x2e; else select strap picks 0x2c/0x2d.
// RL22: address latched on first matching transfer at eighth scl rise.
// RL23: alert goes low when any unmasked status bit is set.
// RL24: non-matching address leaves sda released for the transfer.
module smbrp_top #(
  parameter int TIMEOUT_CYC = smbrp_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_strap_addr_en,
  input  wire logic       i_strap_addr_sel,
  input  wire logic       i_alert_cause,
  output logic            o_alert_n,
  output logic            o_reg_wr,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_timeout_off
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_IGNORE} smbrp_state_type;

  // ****************************************
  // input synchronisers and edge detection
  // ****************************************
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_ff;
  logic       sda_ff;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_ff      <= 1'b1;
      sda_ff      <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      scl_ff      <= scl_sync_ff[1];
      sda_ff      <= sda_sync_ff[1];
    end
  end

  wire scl_s    = scl_sync_ff[1];
  wire sda_s    = sda_sync_ff[1];
  wire scl_rise = scl_s & ~scl_ff;
  wire scl_fall = ~scl_s & scl_ff;
  wire start_ev = scl_s & scl_ff & sda_ff & ~sda_s;      // RL11
  wire stop_ev  = scl_s & scl_ff & ~sda_ff & sda_s;      // RL2

  // ****************************************
  // strap sampling and address selection
  // ****************************************
  logic       straps_taken_ff;
  logic [6:0] sel_addr_ff;
  logic       addr_locked_ff;
  logic [1:0] en_sync_ff;
  logic [1:0] sel_sync_ff;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_sync_ff  <= 2'h0;
      sel_sync_ff <= 2'h0;
    end else begin
      en_sync_ff  <= {en_sync_ff[0], i_strap_addr_en};
      sel_sync_ff <= {sel_sync_ff[0], i_strap_addr_sel};
    end
  end

  // ****************************************
  // protocol state
  // ****************************************
  smbrp_state_type state_ff;
  logic [3:0]      bit_cnt_ff;
  logic [7:0]      shift_ff;
  logic [1:0]      byte_cnt_ff;
  logic            ack_slot_ff;
  logic            is_ara_ff;
  logic [7:0]      tx_ff;
  logic [7:0]      ptr_ff;
  logic [7:0]      cfg_ff;
  logic [$clog2(TIMEOUT_CYC + 1)-1:0] idle_cnt_ff;
  logic            nack_ff;
  logic            lost_ff;

  wire [7:0] rx_byte  = {shift_ff[6:0], sda_s};
  wire       own_hit  = (rx_byte[7:1] == sel_addr_ff);   // RL10
  wire       timeout  = ~cfg_ff[smbrp_pkg::TIMEOUT_OFF_BIT] && (state_ff != ST_IDLE) &&
                        (idle_cnt_ff >= ($bits(idle_cnt_ff))'(TIMEOUT_CYC - 1)); // RL19 RL20

  // straps follow the pins until the first matching address is latched
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      straps_taken_ff <= 1'b0;
      sel_addr_ff     <= smbrp_pkg::ADDR_DEFAULT;
      addr_locked_ff  <= 1'b0;
    end else begin
      straps_taken_ff <= 1'b1;
      if (!addr_locked_ff) begin
        if (en_sync_ff[1])                                        // RL21
          sel_addr_ff <= smbrp_pkg::ADDR_DEFAULT;
        else
          sel_addr_ff <= {smbrp_pkg::ADDR_HIGH_BITS, 1'b0, sel_sync_ff[1]};
      end
      // the address byte's eighth rise: seven address bits already shifted in
      if (state_ff == ST_ADDR && scl_rise && bit_cnt_ff == 4'h7 && !ack_slot_ff &&
          straps_taken_ff && own_hit)
        addr_locked_ff <= 1'b1;                                   // RL22
    end
  end

  // bus-idle counter: any scl or sda change counts as activity
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn)
      idle_cnt_ff <= '0;
    else if (state_ff == ST_IDLE || scl_s != scl_ff || sda_s != sda_ff)
      idle_cnt_ff <= '0;
    else if (!timeout)
      idle_cnt_ff <= idle_cnt_ff + 1'b1;                          // RL19
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      byte_cnt_ff <= 2'h0;
      ack_slot_ff <= 1'b0;
      is_ara_ff   <= 1'b0;
      nack_ff     <= 1'b0;
    end else if (stop_ev || timeout) begin
      state_ff    <= ST_IDLE;                                     // RL19 RL3 RL4
      ack_slot_ff <= 1'b0;
    end else if (start_ev) begin
      state_ff    <= ST_ADDR;                                     // RL11 RL14
      bit_cnt_ff  <= 4'h0;
      byte_cnt_ff <= 2'h0;
      ack_slot_ff <= 1'b0;
      is_ara_ff   <= 1'b0;
    end else if (scl_rise) begin
      if (ack_slot_ff) begin
        nack_ff <= sda_s;                                         // RL4 RL15
      end else if (bit_cnt_ff < 4'(smbrp_pkg::BITS_PER_BYTE)) begin
        shift_ff   <= rx_byte;
        bit_cnt_ff <= bit_cnt_ff + 4'h1;                          // RL1
      end
    end else if (scl_fall) begin
      if (ack_slot_ff) begin
        ack_slot_ff <= 1'b0;
        bit_cnt_ff  <= 4'h0;
        if (state_ff == ST_READ && nack_ff)
          state_ff <= ST_IGNORE;                                  // RL15 RL6
      end else if (bit_cnt_ff == 4'(smbrp_pkg::BITS_PER_BYTE)) begin
        case (state_ff)
          ST_ADDR: begin
            is_ara_ff <= (shift_ff[7:1] == smbrp_pkg::ALERT_RESP_ADDR) & shift_ff[0] & ~o_alert_n;
            // a nack left over from the last read must not suppress this address ack
            nack_ff   <= 1'b0;
            if (shift_ff[7:1] == sel_addr_ff) begin
              state_ff    <= shift_ff[0] ? ST_READ : ST_WRITE;   // RL5
              ack_slot_ff <= 1'b1;
            end else if ((shift_ff[7:1] == smbrp_pkg::ALERT_RESP_ADDR) & shift_ff[0] & ~o_alert_n) begin
              state_ff    <= ST_READ;                             // RL16
              ack_slot_ff <= 1'b1;
            end else begin
              state_ff <= ST_IGNORE;                              // RL24
            end
          end
          ST_WRITE: begin
            if (byte_cnt_ff < 2'h2) begin
              byte_cnt_ff <= byte_cnt_ff + 2'h1;
              ack_slot_ff <= 1'b1;                                // RL12 RL13
            end else begin
              state_ff <= ST_IGNORE;                              // RL6
            end
          end
          ST_READ: begin
            ack_slot_ff <= 1'b1;
            nack_ff     <= 1'b1;
          end
          default: state_ff <= ST_IGNORE;
        endcase
      end
    end
  end

  // pointer and register writes happen at the falling edge that opens the ack slot
  wire wr_byte = scl_fall && !ack_slot_ff && !stop_ev && !timeout && !start_ev &&
                 bit_cnt_ff == 4'(smbrp_pkg::BITS_PER_BYTE) && state_ff == ST_WRITE;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr_ff      <= 8'h00;
      cfg_ff      <= smbrp_pkg::GEN_CFG_ONE_RST;
      o_reg_wr    <= 1'b0;
      o_reg_wdata <= 8'h00;
    end else begin
      o_reg_wr <= 1'b0;
      if (wr_byte && byte_cnt_ff == 2'h0)
        ptr_ff <= shift_ff;                                       // RL7 RL9
      if (wr_byte && byte_cnt_ff == 2'h1) begin
        o_reg_wr    <= 1'b1;                                      // RL8
        o_reg_wdata <= shift_ff;
        if (ptr_ff == smbrp_pkg::REG_GEN_CFG_ONE)
          cfg_ff <= shift_ff;                                     // RL20
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_addr    <= 8'h00;
      o_timeout_off <= 1'b0;
    end else begin
      o_reg_addr    <= ptr_ff;                                    // RL9 RL14
      o_timeout_off <= cfg_ff[smbrp_pkg::TIMEOUT_OFF_BIT];
    end
  end

  // ****************************************
  // sda driver
  // ****************************************
  // read data is captured as the address ack slot closes
  wire read_load = scl_fall && ack_slot_ff && state_ff == ST_READ && bit_cnt_ff == 4'(smbrp_pkg::BITS_PER_BYTE)
                   && byte_cnt_ff == 2'h0 && !nack_ff;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_ff <= 8'h00;
    end else if (read_load) begin
      tx_ff <= is_ara_ff ? {sel_addr_ff, 1'b0} : (ptr_ff == smbrp_pkg::REG_GEN_CFG_ONE ? cfg_ff : i_reg_rdata); // RL16
    end else if (scl_fall && state_ff == ST_READ && !ack_slot_ff && bit_cnt_ff != 4'h0) begin
      tx_ff <= {tx_ff[6:0], 1'b1};
    end
  end

  // arbitration: a released one read back as zero means another device won
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn)
      lost_ff <= 1'b0;
    else if (start_ev || state_ff == ST_IDLE)
      lost_ff <= 1'b0;
    else if (scl_rise && state_ff == ST_READ && !ack_slot_ff && o_sda_oe == 1'b0 && !sda_s && is_ara_ff)
      lost_ff <= 1'b1;                                            // RL17
  end

  logic drive_low;
  always_comb begin
    drive_low = 1'b0;
    if (ack_slot_ff && !(state_ff == ST_READ && bit_cnt_ff == 4'(smbrp_pkg::BITS_PER_BYTE) && nack_ff))
      drive_low = 1'b1;                                           // RL1
    if (state_ff == ST_READ && !ack_slot_ff && !lost_ff && bit_cnt_ff < 4'(smbrp_pkg::BITS_PER_BYTE) &&
        !tx_ff[7] && byte_cnt_ff == 2'h0)
      drive_low = 1'b1;
    if (stop_ev || start_ev || timeout || state_ff == ST_IDLE || state_ff == ST_IGNORE)
      drive_low = 1'b0;                                           // RL19 RL24
  end

  // sda only changes while scl is held low; a timeout may release it at any time
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sda_oe <= 1'b0;
      o_sda    <= 1'b0;
    end else begin
      o_sda <= 1'b0;
      if (!scl_s || timeout)
        o_sda_oe <= drive_low;                                    // RL2
    end
  end

  // ****************************************
  // alert output
  // ****************************************
  logic [1:0] cause_sync_ff;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cause_sync_ff <= 2'h0;
      o_alert_n     <= 1'b1;
    end else begin
      cause_sync_ff <= {cause_sync_ff[0], i_alert_cause};
      o_alert_n     <= ~cause_sync_ff[1];                         // RL23 RL18
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_stop_to_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    stop_ev |=> state_ff == ST_IDLE) else $error("stop did not idle the port"); // RL2

  a_ptr_first_byte: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr_byte && byte_cnt_ff == 2'h0 |=> ptr_ff == $past(shift_ff)) else $error("pointer not loaded"); // RL7

  a_second_byte_wr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr_byte && byte_cnt_ff == 2'h1 |=> o_reg_wr && o_reg_wdata == $past(shift_ff)) else $error("data write missed"); // RL8

  a_ignore_released: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    state_ff == ST_IGNORE ##1 state_ff == ST_IGNORE |-> !o_sda_oe) else $error("sda driven while ignoring"); // RL24

  a_timeout_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    timeout |=> state_ff == ST_IDLE ##1 !o_sda_oe) else $error("timeout did not release"); // RL19

  a_cfg_disables: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    cfg_ff[smbrp_pkg::TIMEOUT_OFF_BIT] |-> !timeout) else $error("timeout fired while disabled"); // RL20

  a_addr_fixed_high: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sel_addr_ff[6:2] == smbrp_pkg::ADDR_HIGH_BITS) else $error("address high bits wrong"); // RL10

  a_addr_locked: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    addr_locked_ff && $past(addr_locked_ff) |-> $stable(sel_addr_ff)) else $error("locked address moved"); // RL22

  a_start_fresh: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    start_ev && !stop_ev && !timeout |=> state_ff == ST_ADDR && byte_cnt_ff == 2'h0) else $error("repeated start"); // RL11

  a_sda_scl_low: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(o_sda_oe) |-> $past(!scl_s)) else $error("sda driven while scl high"); // RL2

endmodule

`default_nettype wire

// ===== smbrp_master.sv
// behavioural smbus master driving bus clock and data
`timescale 1ns/1ps
`default_nettype none
module smbrp_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // one quarter of a 400 ns bus clock period, changed on the falling edge
  task automatic phase(input logic c, input logic d);
    o_scl = c;
    o_sda = d;
    repeat (2) @(negedge i_clk);
  endtask
  // data moves only while scl is low; start is sda falling with scl high
  task automatic start();
    phase(1'b0, o_sda);
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0);
  endtask
  task automatic stop();
    phase(1'b0, o_sda);
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
  endtask
  task automatic bit_io(input logic b, output logic s);
    phase(1'b0, o_sda);
    phase(1'b0, b);
    phase(1'b1, b);
    s = i_sda;
    phase(1'b1, b);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // a high acknowledge ends the read before the stop
  task automatic rbyte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
  endtask
  // leaves scl high in the acknowledge slot so the bus goes quiet
  task automatic hold_ack();
    phase(1'b0, o_sda);
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// ===== smbus_slave_register_port_test.sv
// self-checking bench for the smbus slave register port
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_register_port_test;
  logic       i_ref_clk;
  logic       i_rstn;
  logic       scl;
  logic       m_sda;
  wire logic  sda_line;
  logic       o_sda;
  logic       o_sda_oe;
  logic       strap_en;
  logic       strap_sel;
  logic       cause;
  logic       o_alert_n;
  logic       o_reg_wr;
  logic [7:0] o_reg_addr;
  logic [7:0] o_reg_wdata;
  logic [7:0] i_reg_rdata;
  logic       o_timeout_off;
  logic [7:0] rf [256];
  logic [7:0] model_mem [256];
  logic [7:0] exp_ptr;
  logic [7:0] exp_dat;
  logic [7:0] seed;
  logic [7:0] p;
  logic [7:0] d;
  logic [6:0] own;
  logic       bus_ack;
  logic       bus_bit;
  int         err_count;
  int         comparisons;
  // pull-up on the data line; either party may pull it low
  assign sda_line = (o_sda_oe ? o_sda : 1'b1) & m_sda;
  assign i_reg_rdata = rf[o_reg_addr];
  always #25 i_ref_clk = ~i_ref_clk;
  smbrp_top #(.TIMEOUT_CYC(200)) smbrp_top_inst (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_line), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_strap_addr_en(strap_en), .i_strap_addr_sel(strap_sel),
    .i_alert_cause(cause), .o_alert_n(o_alert_n), .o_reg_wr(o_reg_wr), .o_reg_addr(o_reg_addr),
    .o_reg_wdata(o_reg_wdata), .i_reg_rdata(i_reg_rdata), .o_timeout_off(o_timeout_off));
  smbrp_master smbrp_master_inst (.i_clk(i_ref_clk), .i_sda(sda_line), .o_scl(scl), .o_sda(m_sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // ea bit 0 is the address acknowledge, bit k the acknowledge of byte k
  task automatic write_tx(input logic [6:0] a, input int n, input logic [23:0] bs, input logic [3:0] ea,
                          input logic rs);
    logic ack;
    smbrp_master_inst.start();
    smbrp_master_inst.wbyte({a, 1'b0}, ack);
    chk({7'h00, ack}, {7'h00, ea[0]});
    for (int k = 0; k < n; k++) begin
      smbrp_master_inst.wbyte(bs[23 - 8 * k -: 8], ack);
      chk({7'h00, ack}, {7'h00, ea[k + 1]});
    end
    if (!rs) smbrp_master_inst.stop();
  endtask
  task automatic read_tx(input logic [6:0] a, input logic ea, input logic [7:0] ed);
    logic ack;
    logic [7:0] got;
    smbrp_master_inst.start();
    smbrp_master_inst.wbyte({a, 1'b1}, ack);
    chk({7'h00, ack}, {7'h00, ea});
    if (ea) begin
      smbrp_master_inst.rbyte(got);
      chk(got, ed);
    end
    smbrp_master_inst.stop();
  endtask
  task automatic stall(input logic exp_oe);
    logic s;
    smbrp_master_inst.start();
    for (int i = 7; i >= 0; i--) smbrp_master_inst.bit_io(i == 0 ? 1'b0 : own[i - 1], s);
    smbrp_master_inst.hold_ack();
    chk({7'h00, o_sda_oe}, 8'h01);
    repeat (260) @(negedge i_ref_clk);
    chk({7'h00, o_sda_oe}, {7'h00, exp_oe});
    smbrp_master_inst.stop();
  endtask
  // every register write must hit the pointer with the data just sent; looked at mid-cycle
  always @(negedge i_ref_clk) begin
    if (o_reg_wr === 1'b1) begin
      chk(o_reg_addr, exp_ptr);
      chk(o_reg_wdata, exp_dat);
      rf[o_reg_addr] <= o_reg_wdata;
    end
  end
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    err_count++;
    results();
  end
  initial begin
    {i_ref_clk, i_rstn, strap_en, strap_sel, cause, err_count, comparisons} = {5'b00010, 64'd0};
    seed = 8'h51;
    own = {smbrp_pkg::ADDR_HIGH_BITS, 2'b01};
    for (int i = 0; i < 256; i++) rf[i] = 8'(i) ^ 8'h5a;
    for (int i = 0; i < 256; i++) model_mem[i] = 8'(i) ^ 8'h5a;
    repeat (4) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    chk({o_sda_oe, o_alert_n, o_timeout_off, o_reg_wr}, 8'h04);
    $display("test reset done");
    {exp_ptr, exp_dat} = 16'h1177;
    model_mem[8'h11] = 8'h77;
    write_tx(own, 2, 24'h117700, 4'b0111, 1'b0);
    strap_en = 1'b1;
    strap_sel = 1'b0;
    write_tx(smbrp_pkg::ADDR_DEFAULT, 1, 24'h220000, 4'b0000, 1'b0);
    write_tx(smbrp_pkg::ADDR_SEL_LOW, 2, 24'h3344aa, 4'b0000, 1'b0);
    read_tx(own, 1'b1, 8'h77);
    $display("test address done");
    for (int t = 0; t < 4; t++) begin
      seed = lfsr(seed);
      p = (seed == 8'h40) ? 8'h41 : seed;
      seed = lfsr(seed);
      d = seed;
      {exp_ptr, exp_dat} = {p, d};
      model_mem[p] = d;
      write_tx(own, 2, {p, d, 8'h00}, 4'b0111, 1'b0);
      exp_ptr = p ^ 8'h01;
      write_tx(own, 1, {exp_ptr, 16'h0000}, 4'b0011, 1'b1);
      read_tx(own, 1'b1, model_mem[exp_ptr]);
      read_tx(own, 1'b1, model_mem[exp_ptr]);
      {exp_ptr, exp_dat} = {p, ~d};
      model_mem[p] = ~d;
      write_tx(own, 3, {p, ~d, d}, 4'b0111, 1'b0);
      read_tx(own, 1'b1, model_mem[p]);
    end
    $display("test transfers done");
    stall(1'b0);
    {exp_ptr, exp_dat} = 16'h4040;
    write_tx(own, 2, 24'h404000, 4'b0111, 1'b0);
    chk({7'h00, o_timeout_off}, 8'h01);
    read_tx(own, 1'b1, 8'h40);
    stall(1'b1);
    exp_dat = smbrp_pkg::GEN_CFG_ONE_RST;
    write_tx(own, 2, {16'h4000, 8'h00}, 4'b0111, 1'b0);
    chk({7'h00, o_timeout_off}, 8'h00);
    $display("test timeout done");
    cause = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    chk({7'h00, o_alert_n}, 8'h00);
    read_tx(smbrp_pkg::ALERT_RESP_ADDR, 1'b1, {own, 1'b0});
    // a lower-addressed rival answers too; the port must back off after losing
    d = {own - 7'h03, 1'b0};
    smbrp_master_inst.start();
    smbrp_master_inst.wbyte({smbrp_pkg::ALERT_RESP_ADDR, 1'b1}, bus_ack);
    chk({7'h00, bus_ack}, 8'h01);
    for (int i = 7; i >= 0; i--) smbrp_master_inst.bit_io(d[i], p[i]);
    smbrp_master_inst.bit_io(1'b1, bus_bit);
    smbrp_master_inst.stop();
    chk(p, d);
    cause = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    chk({7'h00, o_alert_n}, 8'h01);
    read_tx(smbrp_pkg::ALERT_RESP_ADDR, 1'b0, 8'h00);
    $display("test alert done");
    // fresh resets pick the address from the straps again
    for (int r = 0; r < 2; r++) begin
      i_rstn = 1'b0;
      strap_en = (r == 0);
      strap_sel = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      i_rstn = 1'b1;
      repeat (6) @(negedge i_ref_clk);
      own = (r == 0) ? smbrp_pkg::ADDR_DEFAULT : smbrp_pkg::ADDR_SEL_LOW;
      {exp_ptr, exp_dat} = {8'h12, 8'h34 + 8'(r)};
      model_mem[exp_ptr] = exp_dat;
      write_tx(own, 2, {exp_ptr, exp_dat, 8'h00}, 4'b0111, 1'b0);
      read_tx(own, 1'b1, model_mem[exp_ptr]);
    end
    $display("test strap reset done");
    results();
  end
endmodule
`default_nettype wire
